// >>> verification/pbg_rf_model.sv
// write back sink standing for the cpu register file
`default_nettype none
module pbg_rf_model
  import pbg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // destination write back
  input  wire logic        res_wr_en,
  input  wire logic        res_side,
  input  wire logic [4:0]  res_dst_idx,
  input  wire logic [31:0] res_data,
  // observation
  output logic      [31:0] write_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [2][32];
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      write_count <= 32'h0;
    end
    else if (res_wr_en)
    begin
      regs[res_side][res_dst_idx] <= res_data;
      write_count <= write_count + 32'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the packed byte dot and galois datapath
`default_nettype none
module tb_top
  import pbg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] data; logic [4:0] idx; logic side; int due;} pbg_note_type;
  logic        clk_sys, rst, in_valid, in_cond_true, in_side, ctl_poly_wr_en;
  logic [4:0]  in_opfield, in_dst_idx;
  logic [31:0] first_source_operand, second_source_operand, ctl_poly_wr_data;
  logic [31:0] ctl_poly_rd_data, res_data, write_count, poly_shadow;
  logic        res_wr_en, res_side;
  logic [4:0]  res_dst_idx;
  pbg_note_type notes[$];
  pbg_note_type n;
  int err_count = 0, checks_done = 0, cyc = 0, writes_due = 0, i;
  int seed = 32'h6142b027;
  logic [31:0] a, b;
  //////////////////////////////////////////////////////////////////////////////
  pbg_top u_pbg_top (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_opfield(in_opfield),
    .in_cond_true(in_cond_true), .in_side(in_side), .in_dst_idx(in_dst_idx),
    .first_source_operand(first_source_operand), .second_source_operand(second_source_operand),
    .ctl_poly_wr_en(ctl_poly_wr_en), .ctl_poly_wr_data(ctl_poly_wr_data),
    .ctl_poly_rd_data(ctl_poly_rd_data), .res_wr_en(res_wr_en), .res_side(res_side),
    .res_dst_idx(res_dst_idx), .res_data(res_data));
  pbg_rf_model u_pbg_rf_model (.clk_sys(clk_sys), .rst(rst), .res_wr_en(res_wr_en), .res_side(res_side),
    .res_dst_idx(res_dst_idx), .res_data(res_data), .write_count(write_count));
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [7:0] gm(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] t;
    logic [7:0] p, m;
    logic [2:0] sz;
    sz = poly_shadow[26:24];
    m = 8'hff >> (3'h7 - sz);
    t = {1'b0, x & m};
    p = 8'h00;
    for (int k = 0; k <= sz; k++)
    begin
      if (y[k]) p ^= t[7:0];
      t = t << 1;
      if (t[sz + 1]) t = (t ^ (9'h001 << (sz + 1))) ^ {1'b0, poly_shadow[7:0] & m};
    end
    return p & m;
  endfunction
  // drive one issue and note its expected write back
  task automatic issue(input logic [4:0] opf, input logic cond, input logic [31:0] x, input logic [31:0] y);
    pbg_note_type e;
    @(negedge clk_sys);
    {in_valid, in_opfield, in_cond_true, first_source_operand, second_source_operand} = {1'b1, opf, cond, x, y};
    in_side = 1'($random(seed));
    in_dst_idx = 5'($random(seed));
    e.idx = in_dst_idx;
    e.side = in_side;
    e.due = cyc + PBG_EXEC_STAGES;
    e.data = 32'h0;
    for (int k = 0; k < 4; k++)
      if (opf == PBG_OPF_DOT) e.data += x[8*k +: 8] * y[8*k +: 8];
      else e.data[8*k +: 8] = gm(x[8*k +: 8], y[8*k +: 8]);
    if (cond && (opf == PBG_OPF_DOT || opf == PBG_OPF_GF))
    begin
      notes.push_back(e);
      writes_due++;
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clk_sys) in_valid = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  always @(negedge clk_sys)
    if (!rst && res_wr_en !== 1'b0)
    begin
      n = notes.size() > 0 ? notes.pop_front() : '{32'hdeadbeef, 5'h0, 1'b0, -1};
      check(res_data, n.data);
      check({26'h0, res_side, res_dst_idx}, {26'h0, n.side, n.idx});
      check(cyc, n.due);
    end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {in_valid, in_opfield, in_cond_true, in_side, in_dst_idx} = 13'h0000;
    {first_source_operand, second_source_operand, ctl_poly_wr_data} = 96'h0;
    ctl_poly_wr_en = 1'b0;
    poly_shadow = 32'h0700001d;
    rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    check(ctl_poly_rd_data, poly_shadow);
    // lanes unsigned, boundary sum, back to back
    issue(PBG_OPF_DOT, 1'b1, 32'h6a321193, 32'hb1746ca4);
    issue(PBG_OPF_DOT, 1'b1, 32'hffffffff, 32'hffffffff);
    for (i = 0; i < 20; i++) issue(PBG_OPF_DOT, 1'b1, $random(seed), $random(seed));
    // galois lanes, independence and swapped sources
    issue(PBG_OPF_GF, 1'b1, 32'h80808080, 32'h02040810);
    issue(PBG_OPF_GF, 1'b1, 32'h5ac3e71f, 32'h00010101);
    for (i = 0; i < 20; i++)
    begin
      a = $random(seed);
      b = $random(seed);
      issue(PBG_OPF_GF, 1'b1, a, b);
      issue(PBG_OPF_GF, 1'b1, b, a);
    end
    // false predicate writes nothing; opfields 00 to 07, of which only dot 06 writes
    issue(PBG_OPF_DOT, 1'b0, 32'h01010101, 32'h01010101);
    issue(PBG_OPF_GF, 1'b0, 32'h01010101, 32'h01010101);
    for (i = 0; i < 8; i++) issue(5'h00 + i[4:0], 1'b1, $random(seed), $random(seed));
    // control move changes the field settings
    for (i = 0; i < 6; i++)
    begin
      idle(5);
      @(negedge clk_sys);
      ctl_poly_wr_en = 1'b1;
      ctl_poly_wr_data = $random(seed);
      @(negedge clk_sys);
      ctl_poly_wr_en = 1'b0;
      poly_shadow = ctl_poly_wr_data & PBG_POLY_WR_MASK;
      check(ctl_poly_rd_data, poly_shadow);
      repeat (6) issue(PBG_OPF_GF, 1'b1, $random(seed), $random(seed));
    end
    idle(10);
    check(write_count, writes_due);
    check(notes.size(), 0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> verilog/pbg_dot.sv
// unsigned four lane byte dot product
`default_nettype none
module pbg_dot
  import pbg_pkg::*;
(
  // operands
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  // sum of lane products
  output logic      [31:0] sum
);
  logic [15:0] prod [PBG_LANES];

  genvar g;
  generate
    for (g = 0; g < PBG_LANES; g++)
    begin : g_lane
      assign prod[g] = {8'h00, a[g*8 +: 8]} * {8'h00, b[g*8 +: 8]};
    end
  endgenerate

  assign sum = {16'h0000, prod[0]} + {16'h0000, prod[1]} + {16'h0000, prod[2]} + {16'h0000, prod[3]};
endmodule
`default_nettype wire

// >>> verilog/pbg_gf_lane.sv
// one byte lane of the galois field multiply
`default_nettype none
module pbg_gf_lane
  import pbg_pkg::*;
(
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  // field settings
  input  wire logic [7:0] poly,
  input  wire logic [2:0] size,
  // product
  output logic      [7:0] p
);
  logic [7:0] mask;
  logic [7:0] am;
  logic [7:0] bm;
  logic [7:0] acc;
  logic       top;

  always_comb
  begin
    mask = 8'hff >> (3'h7 - size);
    am   = a & mask;
    bm   = b & mask;
    acc  = 8'h00;
    top  = 1'b0;
    // symmetric in both operands
    // shift and add, reduced by the generator at each step
    for (int i = 7; i >= 0; i--)
    begin
      top = acc[size];
      acc = (acc << 1) & mask;
      if (top)
      begin
        acc = acc ^ (poly & mask);
      end
      if (bm[i])
      begin
        acc = acc ^ am;
      end
    end
    p = acc;
  end
endmodule
`default_nettype wire

// >>> verilog/pbg_pkg.sv
// shared constants for the packed byte dot and galois multiply datapath
`default_nettype none
package pbg_pkg;
  // operation select field values
  localparam logic [4:0]  PBG_OPF_DOT       = 5'h06;
  localparam logic [4:0]  PBG_OPF_GF        = 5'h11;
  // field widths
  localparam int          PBG_LANES         = 4;
  localparam int          PBG_LANE_W        = 8;
  localparam int          PBG_WORD_W        = 32;
  localparam int          PBG_REG_IDX_W     = 5;
  // polynomial generator register layout
  localparam int          PBG_POLY_LSB      = 0;
  localparam int          PBG_POLY_W        = 8;
  localparam int          PBG_SIZE_LSB      = 24;
  localparam int          PBG_SIZE_W        = 3;
  localparam logic [31:0] PBG_POLY_WR_MASK  = 32'h070000ff;
  localparam logic [31:0] PBG_POLY_RST      = 32'h0700001d;
  // pipeline timing
  localparam int          PBG_EXEC_STAGES   = 4;
  localparam int          PBG_DELAY_SLOTS   = PBG_EXEC_STAGES - 1;
  // largest possible dot product
  localparam logic [31:0] PBG_DOT_MAX       = 32'h0003f804;
  // operation kinds carried down the pipe
  typedef enum logic [1:0] {PBG_OP_NONE, PBG_OP_DOT, PBG_OP_GF} pbg_op_type;
endpackage
`default_nettype wire

// >>> verilog/pbg_top.sv
// multiply unit datapath for packed byte dot and galois multiply
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - dot product on opfield 00110, either unit
// - dot lanes are unsigned bytes, no sign
// - sum four lane products into 32 bits
// - galois multiply each matching byte lane
// - lane n product lands in byte n
// - galois lanes independent, never summed
// - field size and generator from control register
// - control move writes the generator register
// - reset generator 0x1d, size 7
// - galois result same with sources swapped
module pbg_top
  import pbg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // instruction issue
  input  wire logic        in_valid,
  input  wire logic [4:0]  in_opfield,
  input  wire logic        in_cond_true,
  input  wire logic        in_side,
  input  wire logic [4:0]  in_dst_idx,
  input  wire logic [31:0] first_source_operand,
  input  wire logic [31:0] second_source_operand,
  // control register move
  input  wire logic        ctl_poly_wr_en,
  input  wire logic [31:0] ctl_poly_wr_data,
  output logic      [31:0] ctl_poly_rd_data,
  // destination write back
  output logic             res_wr_en,
  output logic             res_side,
  output logic      [4:0]  res_dst_idx,
  output logic      [31:0] res_data
);
  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [31:0] poly_reg;
    pbg_op_type  s1_op;
    logic        s1_side;
    logic [4:0]  s1_dst;
    logic [31:0] s1_a;
    logic [31:0] s1_b;
    logic [7:0]  s1_poly;
    logic [2:0]  s1_size;
    logic        s2_wr;
    logic        s2_side;
    logic [4:0]  s2_dst;
    logic [31:0] s2_data;
    logic        s3_wr;
    logic        s3_side;
    logic [4:0]  s3_dst;
    logic [31:0] s3_data;
    logic        s4_wr;
    logic        s4_side;
    logic [4:0]  s4_dst;
    logic [31:0] s4_data;
  } pbg_state_type;

  localparam pbg_state_type PBG_STATE_RST = '{
    poly_reg: PBG_POLY_RST,
    s1_op:    PBG_OP_NONE,
    default:  '0
  };

  pbg_state_type state_reg;
  pbg_state_type state_next;
  logic [31:0]   dot_sum;
  logic [31:0]   gf_packed;
  logic          issue_ok;

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic on the first stage operands
  pbg_dot u_dot (
    .a   (state_reg.s1_a),
    .b   (state_reg.s1_b),
    .sum (dot_sum)
  );

  genvar g;
  generate
    for (g = 0; g < PBG_LANES; g++)
    begin : g_gf
      pbg_gf_lane u_lane (
        .a    (state_reg.s1_a[g*8 +: 8]),
        .b    (state_reg.s1_b[g*8 +: 8]),
        .poly (state_reg.s1_poly),
        .size (state_reg.s1_size),
        .p    (gf_packed[g*8 +: 8])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // next state
  assign issue_ok = in_valid && in_cond_true;

  always_comb
  begin
    state_next = state_reg;
    if (ctl_poly_wr_en)
    begin
      state_next.poly_reg = ctl_poly_wr_data & PBG_POLY_WR_MASK;
    end
    state_next.s1_op   = PBG_OP_NONE;
    state_next.s1_side = in_side;
    state_next.s1_dst  = in_dst_idx;
    state_next.s1_a    = first_source_operand;
    state_next.s1_b    = second_source_operand;
    state_next.s1_poly = state_reg.poly_reg[PBG_POLY_LSB +: PBG_POLY_W];
    state_next.s1_size = state_reg.poly_reg[PBG_SIZE_LSB +: PBG_SIZE_W];
    if (issue_ok)
    begin
      if (in_opfield == PBG_OPF_DOT)
      begin
        state_next.s1_op = PBG_OP_DOT;
      end
      else if (in_opfield == PBG_OPF_GF)
      begin
        state_next.s1_op = PBG_OP_GF;
      end
    end
    // second stage picks the result
    state_next.s2_wr   = state_reg.s1_op != PBG_OP_NONE;
    state_next.s2_side = state_reg.s1_side;
    state_next.s2_dst  = state_reg.s1_dst;
    unique case (state_reg.s1_op)
      PBG_OP_DOT:  state_next.s2_data = dot_sum;
      PBG_OP_GF:   state_next.s2_data = gf_packed;
      PBG_OP_NONE: state_next.s2_data = 32'h00000000;
    endcase
    // third and fourth stages
    state_next.s3_wr   = state_reg.s2_wr;
    state_next.s3_side = state_reg.s2_side;
    state_next.s3_dst  = state_reg.s2_dst;
    state_next.s3_data = state_reg.s2_data;
    state_next.s4_wr   = state_reg.s3_wr;
    state_next.s4_side = state_reg.s3_side;
    state_next.s4_dst  = state_reg.s3_dst;
    state_next.s4_data = state_reg.s3_data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= PBG_STATE_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign res_wr_en        = state_reg.s4_wr;
  assign res_side         = state_reg.s4_side;
  assign res_dst_idx      = state_reg.s4_dst;
  assign res_data         = state_reg.s4_data;
  assign ctl_poly_rd_data = state_reg.poly_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] chk_dot;
  logic [7:0]  chk_swap0;

  assign chk_dot = {24'h000000, first_source_operand[7:0]} * {24'h000000, second_source_operand[7:0]}
                 + {24'h000000, first_source_operand[15:8]} * {24'h000000, second_source_operand[15:8]}
                 + {24'h000000, first_source_operand[23:16]} * {24'h000000, second_source_operand[23:16]}
                 + {24'h000000, first_source_operand[31:24]} * {24'h000000, second_source_operand[31:24]};

  pbg_gf_lane u_chk_swap (
    .a    (state_reg.s1_b[7:0]),
    .b    (state_reg.s1_a[7:0]),
    .poly (state_reg.s1_poly),
    .size (state_reg.s1_size),
    .p    (chk_swap0)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_issue_dot;
    issue_ok && in_opfield == PBG_OPF_DOT;
  endsequence

  sequence s_issue_gf;
    issue_ok && in_opfield == PBG_OPF_GF;
  endsequence

  property p_dot_written;
    s_issue_dot |-> ##4 res_wr_en && res_dst_idx == $past(in_dst_idx, 4);
  endproperty
  a_dot_written: assert property (p_dot_written) else $error("dot issue not written");

  property p_dot_range;
    s_issue_dot |-> ##4 res_data <= PBG_DOT_MAX;
  endproperty
  a_dot_range: assert property (p_dot_range) else $error("dot result out of range");

  property p_dot_value;
    s_issue_dot |-> ##4 res_data == $past(chk_dot, 4);
  endproperty
  a_dot_value: assert property (p_dot_value) else $error("dot result wrong");

  property p_gf_packed;
    s_issue_gf |-> ##4 res_data == $past(gf_packed, 3);
  endproperty
  a_gf_packed: assert property (p_gf_packed) else $error("galois lanes misplaced");

  property p_gf_unit;
    s_issue_gf and (second_source_operand[7:0] == 8'h01 && state_reg.poly_reg == PBG_POLY_RST)
      |-> ##4 res_data[7:0] == $past(first_source_operand[7:0], 4);
  endproperty
  a_gf_unit: assert property (p_gf_unit) else $error("galois times one wrong");

  property p_gf_zero_lane;
    s_issue_gf and (second_source_operand[31:24] == 8'h00) |-> ##4 res_data[31:24] == 8'h00;
  endproperty
  a_gf_zero_lane: assert property (p_gf_zero_lane) else $error("galois lane leaked");

  property p_poly_write;
    ctl_poly_wr_en |=> ctl_poly_rd_data == ($past(ctl_poly_wr_data) & PBG_POLY_WR_MASK);
  endproperty
  a_poly_write: assert property (p_poly_write) else $error("generator write lost");

  property p_poly_reset;
    $fell(rst) |-> ctl_poly_rd_data == PBG_POLY_RST;
  endproperty
  a_poly_reset: assert property (p_poly_reset) else $error("generator reset wrong");

  property p_gf_commute;
    state_reg.s1_op == PBG_OP_GF |-> chk_swap0 == gf_packed[7:0];
  endproperty
  a_gf_commute: assert property (p_gf_commute) else $error("galois not commutative");

  property p_latency;
    issue_ok && (in_opfield == PBG_OPF_DOT || in_opfield == PBG_OPF_GF) |-> ##4 res_wr_en;
  endproperty
  a_latency: assert property (p_latency) else $error("result not at fourth stage");

  property p_false_pred;
    !issue_ok |-> ##4 !res_wr_en;
  endproperty
  a_false_pred: assert property (p_false_pred) else $error("false predicate wrote");
endmodule
`default_nettype wire
